/* File: verilog/operand_addr_pkg.sv */
package operand_addr_pkg;

    // bank-select field inside the status word
    localparam int BANK_LSB = 3;
    localparam int BANK_MSB = 4;
    // direct addresses at or above this reach special function registers
    localparam logic [7:0] SPECIAL_BASE = 8'h80;
    // first byte of bit-addressable internal RAM
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] ADDR_ZERO = 16'h0000;

    typedef enum logic [3:0] {
        MODE_DIRECT = 4'h0,
        MODE_IND_RAM = 4'h1,
        MODE_IND_XRAM = 4'h2,
        MODE_IND_DATA_PTR = 4'h3,
        MODE_REGISTER = 4'h4,
        MODE_ACCUM = 4'h5,
        MODE_IMMEDIATE = 4'h6,
        MODE_INDEXED = 4'h7,
        MODE_BIT = 4'h8
    } mode_t;

    typedef enum logic [2:0] {
        SP_NONE = 3'h0,
        SP_IRAM = 3'h1,
        SP_SPECIAL = 3'h2,
        SP_XDATA = 3'h3,
        SP_CODE = 3'h4,
        SP_IMM = 3'h5,
        SP_ACC = 3'h6
    } space_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_PTR_WAIT = 2'b10
    } state_t;

    typedef struct packed {
        mode_t mode;
        logic [7:0] opcode;
        logic [7:0] field;
        logic is_write;
        logic acc_partner;
    } req_t;

    typedef struct packed {
        space_t space;
        logic [15:0] addr;
        logic [7:0] imm;
        logic is_bit;
        logic [2:0] bit_sel;
    } res_t;

    localparam res_t RES_RESET = '{SP_NONE, ADDR_ZERO, BYTE_ZERO, 1'b0, 3'h0};

endpackage : operand_addr_pkg

/* File: verilog/bit_addr_map.sv */
`timescale 1ns/1ps
`default_nettype none

module bit_addr_map (
    input wire logic [7:0] bit_addr_in,
    output logic [7:0] byte_addr_out,
    output logic is_special_out,
    output logic [2:0] bit_sel_out
);
    import operand_addr_pkg::*;

    wire [7:0] ram_byte;
    wire [7:0] special_byte;

    // low half: 128 bits packed in sixteen ram bytes
    assign ram_byte = BIT_RAM_BASE + {4'h0, bit_addr_in[6:3]};
    // high half: bits of special registers at multiples of eight
    assign special_byte = {bit_addr_in[7:3], 3'h0};
    assign is_special_out = bit_addr_in[7];
    assign byte_addr_out = bit_addr_in[7] ? special_byte : ram_byte;
    assign bit_sel_out = bit_addr_in[2:0];

endmodule : bit_addr_map

`default_nettype wire

/* File: verilog/operand_addr_unit.sv */
// Summary of operation
// - direct operand address is instruction's 8-bit field
// - direct reaches only internal RAM and special registers
// - 8-bit indirect pointer from register zero or one
// - 16-bit indirect address is the data pointer
// - register mode picks one of eight bank registers
// - register-specific instructions act on fixed accumulator
// - immediate mode takes constant from instruction bytes
// - indexed only for code reads, pointer plus accumulator
// - bit mode selects one of 256 bits
// - operands resolve in one or two cycles
// - 128 RAM bits plus bit-addressable special registers
// - external RAM only with accumulator, indirect only
`timescale 1ns/1ps
`default_nettype none

module operand_addr_unit (
    input wire logic SYS_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic REQ_VALID_IN,
    input wire operand_addr_pkg::req_t REQ_IN,
    input wire logic [7:0] ACC_IN,
    input wire logic [15:0] DATA_POINTER_16_IN,
    input wire logic [7:0] STATUS_WORD_IN,
    input wire logic [7:0] PTR_RDATA_IN,
    output logic READY_OUT,
    output logic PTR_RD_OUT,
    output logic [7:0] PTR_ADDR_OUT,
    output logic RESULT_VALID_OUT,
    output operand_addr_pkg::res_t RESULT_OUT,
    output logic ERROR_OUT
);
    import operand_addr_pkg::*;

    state_t state_r;
    state_t state_nxt;
    res_t result_r;
    res_t result_nxt;
    logic valid_r;
    logic valid_nxt;
    logic error_r;
    logic error_nxt;
    logic ptr_rd_r;
    logic [7:0] ptr_addr_r;
    logic ready_r;

    wire take;
    wire [1:0] bank;
    wire [7:0] reg_addr;
    wire [7:0] ptr_reg_addr;
    wire direct_special;
    wire [15:0] indexed_addr;
    wire [7:0] bit_byte;
    wire bit_in_special;
    wire [2:0] bit_sel;
    wire issue_ptr;

    assign take = REQ_VALID_IN && ready_r;
    assign bank = STATUS_WORD_IN[BANK_MSB:BANK_LSB];
    assign reg_addr = {3'h0, bank, REQ_IN.opcode[2:0]};
    assign ptr_reg_addr = {3'h0, bank, 2'h0, REQ_IN.opcode[0]};
    assign direct_special = REQ_IN.field >= SPECIAL_BASE;
    assign indexed_addr = DATA_POINTER_16_IN + {BYTE_ZERO, ACC_IN};
    assign issue_ptr = take && (REQ_IN.mode == MODE_IND_RAM
        || (REQ_IN.mode == MODE_IND_XRAM && REQ_IN.acc_partner));

    bit_addr_map u_bit_map (
        .bit_addr_in(REQ_IN.field),
        .byte_addr_out(bit_byte),
        .is_special_out(bit_in_special),
        .bit_sel_out(bit_sel)
    );

    always_comb begin
        state_nxt = state_r;
        result_nxt = result_r;
        valid_nxt = 1'b0;
        error_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    valid_nxt = 1'b1;
                    result_nxt = RES_RESET;
                    case (REQ_IN.mode)
                        MODE_DIRECT: begin
                            result_nxt.space = direct_special ? SP_SPECIAL : SP_IRAM;
                            result_nxt.addr = {BYTE_ZERO, REQ_IN.field};
                        end
                        MODE_IND_RAM: begin
                            valid_nxt = 1'b0;
                            result_nxt.space = SP_IRAM;
                            state_nxt = ST_PTR_WAIT;
                        end
                        MODE_IND_XRAM: begin
                            valid_nxt = 1'b0;
                            result_nxt.space = SP_XDATA;
                            if (REQ_IN.acc_partner) begin
                                state_nxt = ST_PTR_WAIT;
                            end else begin
                                error_nxt = 1'b1;
                            end
                        end
                        MODE_IND_DATA_PTR: begin
                            if (REQ_IN.acc_partner) begin
                                result_nxt.space = SP_XDATA;
                                result_nxt.addr = DATA_POINTER_16_IN;
                            end else begin
                                valid_nxt = 1'b0;
                                error_nxt = 1'b1;
                            end
                        end
                        MODE_REGISTER: begin
                            result_nxt.space = SP_IRAM;
                            result_nxt.addr = {BYTE_ZERO, reg_addr};
                        end
                        MODE_ACCUM: begin
                            result_nxt.space = SP_ACC;
                        end
                        MODE_IMMEDIATE: begin
                            result_nxt.space = SP_IMM;
                            result_nxt.imm = REQ_IN.field;
                        end
                        MODE_INDEXED: begin
                            if (REQ_IN.is_write) begin
                                valid_nxt = 1'b0;
                                error_nxt = 1'b1;
                            end else begin
                                result_nxt.space = SP_CODE;
                                result_nxt.addr = indexed_addr;
                            end
                        end
                        MODE_BIT: begin
                            result_nxt.space = bit_in_special ? SP_SPECIAL : SP_IRAM;
                            result_nxt.addr = {BYTE_ZERO, bit_byte};
                            result_nxt.is_bit = 1'b1;
                            result_nxt.bit_sel = bit_sel;
                        end
                        default: begin
                            valid_nxt = 1'b0;
                            error_nxt = 1'b1;
                        end
                    endcase
                end
            end
            ST_PTR_WAIT: begin
                // pointer register contents answered during the read strobe
                result_nxt.addr = {BYTE_ZERO, PTR_RDATA_IN};
                valid_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state_r <= ST_IDLE;
            result_r <= RES_RESET;
            valid_r <= 1'b0;
            error_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            result_r <= result_nxt;
            valid_r <= valid_nxt;
            error_r <= error_nxt;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ptr_rd_r <= 1'b0;
            ptr_addr_r <= BYTE_ZERO;
            ready_r <= 1'b1;
        end else begin
            ptr_rd_r <= issue_ptr;
            ptr_addr_r <= issue_ptr ? ptr_reg_addr : ptr_addr_r;
            ready_r <= state_nxt == ST_IDLE;
        end
    end

    assign READY_OUT = ready_r;
    assign PTR_RD_OUT = ptr_rd_r;
    assign PTR_ADDR_OUT = ptr_addr_r;
    assign RESULT_VALID_OUT = valid_r;
    assign RESULT_OUT = result_r;
    assign ERROR_OUT = error_r;

    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    sequence s_ptr_issue;
        take && REQ_IN.mode == MODE_IND_RAM;
    endsequence

    sequence s_ptr_strobe;
        PTR_RD_OUT && !READY_OUT;
    endsequence

    property p_direct;
        take && REQ_IN.mode == MODE_DIRECT |=> RESULT_VALID_OUT
            && RESULT_OUT.addr == {BYTE_ZERO, $past(REQ_IN.field)}
            && RESULT_OUT.space == ($past(REQ_IN.field[7]) ? SP_SPECIAL : SP_IRAM);
    endproperty
    a_direct: assert property (p_direct) else $error("direct operand wrong");

    property p_ind_ptr;
        s_ptr_issue ##1 s_ptr_strobe |=> RESULT_VALID_OUT && RESULT_OUT.space == SP_IRAM
            && RESULT_OUT.addr == {BYTE_ZERO, $past(PTR_RDATA_IN)};
    endproperty
    a_ind_ptr: assert property (p_ind_ptr) else $error("indirect pointer wrong");

    property p_bank;
        issue_ptr |=> PTR_ADDR_OUT == {3'h0, $past(STATUS_WORD_IN[BANK_MSB:BANK_LSB]),
            2'h0, $past(REQ_IN.opcode[0])};
    endproperty
    a_bank: assert property (p_bank) else $error("pointer bank address wrong");

    property p_data_ptr;
        take && REQ_IN.mode == MODE_IND_DATA_PTR && REQ_IN.acc_partner |=> RESULT_VALID_OUT
            && RESULT_OUT.space == SP_XDATA && RESULT_OUT.addr == $past(DATA_POINTER_16_IN);
    endproperty
    a_data_ptr: assert property (p_data_ptr) else $error("data pointer address wrong");

    property p_register;
        take && REQ_IN.mode == MODE_REGISTER |=> RESULT_OUT.addr[7:0]
            == {3'h0, $past(STATUS_WORD_IN[BANK_MSB:BANK_LSB]), $past(REQ_IN.opcode[2:0])};
    endproperty
    a_register: assert property (p_register) else $error("bank register wrong");

    property p_accum;
        take && REQ_IN.mode == MODE_ACCUM |=> RESULT_VALID_OUT && RESULT_OUT.space == SP_ACC;
    endproperty
    a_accum: assert property (p_accum) else $error("accumulator not selected");

    property p_immediate;
        take && REQ_IN.mode == MODE_IMMEDIATE |=> RESULT_OUT.space == SP_IMM
            && RESULT_OUT.imm == $past(REQ_IN.field);
    endproperty
    a_immediate: assert property (p_immediate) else $error("immediate wrong");

    property p_indexed;
        take && REQ_IN.mode == MODE_INDEXED |=> ($past(REQ_IN.is_write) ? ERROR_OUT
            : (RESULT_OUT.space == SP_CODE && RESULT_OUT.addr
            == $past(DATA_POINTER_16_IN) + {BYTE_ZERO, $past(ACC_IN)}));
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed read wrong");

    property p_bit;
        take && REQ_IN.mode == MODE_BIT |=> RESULT_OUT.is_bit
            && RESULT_OUT.bit_sel == $past(REQ_IN.field[2:0])
            && ($past(REQ_IN.field[7]) || RESULT_OUT.addr[7:4] == 4'h2);
    endproperty
    a_bit: assert property (p_bit) else $error("bit operand wrong");

    property p_latency;
        take |-> ##[1:2] (RESULT_VALID_OUT || ERROR_OUT);
    endproperty
    a_latency: assert property (p_latency) else $error("operand too late");

    property p_xram_acc;
        take && REQ_IN.mode == MODE_IND_XRAM && !REQ_IN.acc_partner
            |=> ERROR_OUT && !RESULT_VALID_OUT;
    endproperty
    a_xram_acc: assert property (p_xram_acc) else $error("xram without accumulator");

endmodule : operand_addr_unit

`default_nettype wire

/* File: tb/iram_model.sv */
`timescale 1ns/1ps
`default_nettype none

module iram_model #(
    parameter logic [7:0] KEY = 8'hA5
) (
    input wire logic clk_in,
    input wire logic rd_in,
    input wire logic [7:0] addr_in,
    output logic [7:0] rdata_out
);
    logic [7:0] junk_r = 8'h96;

    // outside a read the line shows a pattern that moves every cycle
    always @(posedge clk_in) begin
        junk_r <= junk_r + 8'h3D;
    end

    // pointer bytes of every bank are a fixed scramble of their address
    assign rdata_out = rd_in ? (addr_in ^ KEY) : junk_r;
endmodule : iram_model

`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import operand_addr_pkg::*;
    localparam logic [7:0] KEY = 8'hA5;
    typedef struct {
        logic err; res_t r; logic ck_addr; logic ck_imm; logic ind;
        logic [7:0] pa; int due;
    } note_t;
    logic clk, rstn, req_valid, ready, ptr_rd, res_valid, err;
    logic [7:0] acc, sw, ptr_rdata, ptr_addr;
    logic [15:0] dp;
    req_t req, q;
    res_t res;
    note_t notes[$];
    note_t n;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;

    operand_addr_unit i_operand_addr_unit (.SYS_CLK_IN(clk), .RESETN_IN(rstn),
        .REQ_VALID_IN(req_valid), .REQ_IN(req), .ACC_IN(acc), .DATA_POINTER_16_IN(dp),
        .STATUS_WORD_IN(sw), .PTR_RDATA_IN(ptr_rdata), .READY_OUT(ready), .PTR_RD_OUT(ptr_rd),
        .PTR_ADDR_OUT(ptr_addr), .RESULT_VALID_OUT(res_valid), .RESULT_OUT(res),
        .ERROR_OUT(err));
    iram_model #(.KEY(KEY)) i_iram_model (.clk_in(clk), .rd_in(ptr_rd), .addr_in(ptr_addr),
        .rdata_out(ptr_rdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done

    function automatic note_t expect_of(req_t r, logic [7:0] a, logic [15:0] d, logic [7:0] s);
        note_t e;
        logic [1:0] bk;
        bk = s[BANK_MSB:BANK_LSB];
        e = '{err: 1'b0, r: RES_RESET, ck_addr: 1'b1, ck_imm: 1'b0, ind: 1'b0,
              pa: {3'h0, bk, 2'h0, r.opcode[0]}, due: 0};
        case (r.mode)
            MODE_DIRECT: begin
                e.r.space = (r.field >= SPECIAL_BASE) ? SP_SPECIAL : SP_IRAM;
                e.r.addr = {8'h00, r.field};
            end
            MODE_IND_RAM: begin
                e.ind = 1'b1;
                e.r.space = SP_IRAM;
                e.r.addr = {8'h00, e.pa ^ KEY};
            end
            MODE_IND_XRAM: begin
                e.err = !r.acc_partner;
                e.ind = r.acc_partner;
                e.r.space = SP_XDATA;
                e.r.addr = {8'h00, e.pa ^ KEY};
            end
            MODE_IND_DATA_PTR: begin
                e.err = !r.acc_partner;
                e.r.space = SP_XDATA;
                e.r.addr = d;
            end
            MODE_REGISTER: begin
                e.r.space = SP_IRAM;
                e.r.addr = {11'h000, bk, r.opcode[2:0]};
            end
            MODE_ACCUM: begin
                e.r.space = SP_ACC;
                e.ck_addr = 1'b0;
            end
            MODE_IMMEDIATE: begin
                e.r.space = SP_IMM;
                e.ck_addr = 1'b0;
                e.ck_imm = 1'b1;
                e.r.imm = r.field;
            end
            MODE_INDEXED: begin
                e.err = r.is_write;
                e.r.space = SP_CODE;
                e.r.addr = d + {8'h00, a};
            end
            MODE_BIT: begin
                e.r.is_bit = 1'b1;
                e.r.bit_sel = r.field[2:0];
                e.r.space = r.field[7] ? SP_SPECIAL : SP_IRAM;
                e.r.addr = r.field[7] ? {8'h00, r.field[7:3], 3'h0}
                    : {8'h00, BIT_RAM_BASE + {4'h0, r.field[6:3]}};
            end
            default: e.err = 1'b1;
        endcase
        return e;
    endfunction : expect_of

    function automatic req_t rand_req();
        return '{mode_t'(4'($urandom_range(0, 9))), 8'($urandom), 8'($urandom),
                 1'($urandom), 1'($urandom)};
    endfunction : rand_req

    // a junk request is held while busy; it must be ignored
    task automatic send(input req_t r);
        note_t e;
        @(negedge clk);
        while (ready !== 1'b1) begin
            req = '{mode_t'(4'hF), 8'hFF, 8'hFF, 1'b1, 1'b0};
            req_valid = 1'b1;
            @(negedge clk);
        end
        acc = 8'($urandom);
        dp = 16'($urandom);
        sw = 8'($urandom);
        req = r;
        req_valid = 1'b1;
        e = expect_of(r, acc, dp, sw);
        // result shows just after the take edge itself, one edge after it for pointer reads
        e.due = cyc + (e.ind ? 2 : 1);
        notes.push_back(e);
    endtask : send

    initial begin
        forever begin
            @(posedge clk);
            cyc++;
            #1;
            check(ready, !ptr_rd);
            if (res_valid === 1'b1 || err === 1'b1) begin
                if (notes.size() == 0) begin
                    check(1, 0);
                end else begin
                    n = notes.pop_front();
                    check(cyc, n.due);
                    check({res_valid, err}, {!n.err, n.err});
                    if (!n.err) begin
                        check(res.space, n.r.space);
                        if (n.ck_addr) check(res.addr, n.r.addr);
                        if (n.ck_imm) check(res.imm, n.r.imm);
                        check({res.is_bit, res.bit_sel}, {n.r.is_bit, n.r.bit_sel});
                        if (n.ind) check(ptr_addr, n.pa);
                    end
                end
            end
        end
    end

    initial begin
        #200000;
        check(0, 1);
        test_done();
    end

    initial begin
        logic [7:0] edges[4];
        edges = '{8'h00, 8'h7F, 8'h80, 8'hFF};
        rstn = 1'b0;
        req_valid = 1'b0;
        req = '{MODE_DIRECT, 8'h00, 8'h00, 1'b0, 1'b0};
        acc = 8'h00;
        dp = 16'h0000;
        sw = 8'h00;
        repeat (10) @(negedge clk);
        check(ready, 1'b1);
        check({ptr_rd, res_valid, err}, 3'h0);
        check(res, RES_RESET);
        rstn = 1'b1;
        void'($urandom(32'h7C99));
        for (int w = 0; w < 3; w++) begin
            for (int m = 0; m < 16; m++) begin
                q = rand_req();
                q.mode = mode_t'(4'(m));
                q.acc_partner = (w != 1);
                q.is_write = (w == 2);
                send(q);
            end
        end
        foreach (edges[i]) begin
            q = rand_req();
            q.field = edges[i];
            q.mode = MODE_BIT;
            send(q);
            q.mode = MODE_DIRECT;
            send(q);
        end
        repeat (500) send(rand_req());
        @(negedge clk);
        req_valid = 1'b0;
        repeat (5) @(negedge clk);
        check(notes.size(), 0);
        test_done();
    end
endmodule : testbench

`default_nettype wire
